// ### prot_otp_cfg.svh
`ifndef PROT_OTP_CFG_SVH
`define PROT_OTP_CFG_SVH

// Storage widths
`define CFG_W         16
`define KEY_W         64
`define STAT_W        8
`define HREG_W        32

// Erased one-time-programmable contents
`define CFG_ERASED    16'hFFFF
`define KEY_ERASED    64'hFFFF_FFFF_FFFF_FFFF
// Reserved mode bits 15:7, 5 and 3
`define CFG_RSV_MASK  16'hFFA8
`define CFG_MODE_OPEN 3'h7

// Mode word fields
`define CFG_R3KEY     6
`define CFG_BOOTLOCK  4
`define CFG_KEYMODE   2
`define CFG_SUPPLY    1
`define CFG_PERM      0

// Status byte fields
`define ST_R3KEY      6
`define ST_GUARD      0

// Host register offsets
`define HR_CTRL       8'h00
`define HR_WLO        8'h04
`define HR_WHI        8'h08
`define HR_RLO        8'h0C
`define HR_RHI        8'h10
`define HR_STAT       8'h14

// Host control fields
`define CTRL_OP_LSB   0
`define CTRL_GO       4
`define CTRL_CLOSE    8
`define CTRL_OP_W     3

// Host status word fields
`define HS_BUSY       0
`define HS_DONE       1
`define HS_ERR        2
`define HS_REFUSED    3
`define HS_WINDOW     4
`define HS_VERIFIED   5
`define HS_UNLOCK     6

`endif

// ### prot_pkg.sv
`default_nettype none

package prot_pkg;

  typedef enum logic [2:0] {
    OP_CFG_READ,
    OP_CFG_PROG,
    OP_KEY_READ,
    OP_KEY_PROG,
    OP_STAT_READ,
    OP_STAT_LATCH
  } op_e;

endpackage

`default_nettype wire

// ### prot_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_otp_cfg.svh"

interface prot_link_if;
  import prot_pkg::*;
  logic              cmd_valid;
  op_e               cmd_op;
  logic [`KEY_W-1:0] cmd_data;
  logic              rsp_valid;
  logic [`KEY_W-1:0] rsp_data;
  logic              rsp_err;

  modport dev  (input  cmd_valid, cmd_op, cmd_data,
                output rsp_valid, rsp_data, rsp_err);
  modport host (output cmd_valid, cmd_op, cmd_data,
                input  rsp_valid, rsp_data, rsp_err);
endinterface

`default_nettype wire

// ### otp_protection_mode_lock.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "prot_otp_cfg.svh"

module otp_protection_mode_lock
  import prot_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Reload pulse from power-up, hardware or software reset
  input  wire logic              reload_in,
  input  wire logic              err_clear_in,
  // Command link
  prot_link_if.dev               link,
  // Protection state
  output logic [`CFG_W-1:0]      config_word_out,
  output logic [`STAT_W-1:0]     status_byte_out,
  output logic                   sector_lock_boot_value_out,
  output logic                   region_write_blocked_out,
  output logic                   region3_read_locked_out,
  output logic                   key_mode_out,
  output logic                   supply_lockdown_out,
  output logic                   permanent_mode_out,
  output logic                   program_error_out
);

  function automatic logic mode_open(input logic [`CFG_W-1:0] c);
    mode_open = (c[`CFG_KEYMODE:`CFG_PERM] == `CFG_MODE_OPEN);
  endfunction

  // Erased cells only ever lose ones
  function automatic logic [`KEY_W-1:0] otp_burn(
    input logic [`KEY_W-1:0] old_v,
    input logic [`KEY_W-1:0] new_v);
    otp_burn = old_v & new_v;
  endfunction

  logic [`CFG_W-1:0]  cfg_q;
  logic [`KEY_W-1:0]  key_q;
  logic [`KEY_W-1:0]  shadow_q;
  logic               r3_q;
  logic               guard_q;
  logic               perr_q;
  logic               rsp_valid_q;
  logic [`KEY_W-1:0]  rsp_data_q;
  logic               rsp_err_q;
  logic [`STAT_W-1:0] stat_byte;
  logic               cfg_wr;
  logic               key_wr;
  logic               prog_fail;
  logic               latch;
  logic [`KEY_W-1:0]  rd_data;
  logic               rd_err;
  logic [`CFG_W-1:0]  cfg_new;
  logic [`KEY_W-1:0]  cfg_burn;

  always_comb begin
    stat_byte = '0;
    stat_byte[`ST_R3KEY] = r3_q;
    stat_byte[`ST_GUARD] = guard_q;
  end

  // Reserved bits forced high so a write never burns them
  assign cfg_new = link.cmd_data[`CFG_W-1:0] | `CFG_RSV_MASK;
  assign cfg_burn = otp_burn({{(`KEY_W-`CFG_W){1'b1}}, cfg_q},
                             {{(`KEY_W-`CFG_W){1'b1}}, cfg_new});

  always_comb begin
    cfg_wr = 1'b0;
    key_wr = 1'b0;
    prog_fail = 1'b0;
    latch = 1'b0;
    rd_data = '0;
    rd_err = 1'b0;
    if (link.cmd_valid) begin
      unique case (link.cmd_op)
        OP_CFG_READ: begin
          rd_data = {{(`KEY_W-`CFG_W){1'b0}}, cfg_q};
        end
        OP_CFG_PROG: begin
          // Any cleared mode lock closes the word for good
          if (mode_open(cfg_q)) begin
            cfg_wr = 1'b1;
          end else begin
            prog_fail = 1'b1;
            rd_err = 1'b1;
          end
        end
        OP_KEY_READ: begin
          if (cfg_q[`CFG_KEYMODE]) begin
            rd_data = shadow_q;
          end else begin
            rd_err = 1'b1;
          end
        end
        OP_KEY_PROG: begin
          if (cfg_q[`CFG_KEYMODE]) begin
            key_wr = 1'b1;
          end else begin
            prog_fail = 1'b1;
            rd_err = 1'b1;
          end
        end
        OP_STAT_READ: begin
          rd_data = {{(`KEY_W-`STAT_W){1'b0}}, stat_byte};
        end
        OP_STAT_LATCH: begin
          latch = 1'b1;
        end
        default: begin
          rd_err = 1'b1;
        end
      endcase
    end
  end

  // Async reset stands for a factory-blank part, not a user reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= `CFG_ERASED;
    end else if (cfg_wr) begin
      cfg_q <= cfg_burn[`CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_q <= `KEY_ERASED;
    end else if (key_wr) begin
      key_q <= otp_burn(key_q, link.cmd_data);
    end
  end

  // Shadow lags the cells by one cycle; not writable from the link
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_q <= `KEY_ERASED;
    end else begin
      shadow_q <= key_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r3_q <= 1'b1;
    end else if (reload_in) begin
      r3_q <= cfg_q[`CFG_R3KEY];
    end
  end

  // Reload wins over a latch in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      guard_q <= 1'b1;
    end else if (reload_in) begin
      guard_q <= cfg_q[`CFG_KEYMODE] & cfg_q[`CFG_PERM];
    end else if (latch) begin
      guard_q <= 1'b1;
    end
  end

  // New failure beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perr_q <= 1'b0;
    end else if (prog_fail) begin
      perr_q <= 1'b1;
    end else if (err_clear_in) begin
      perr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= link.cmd_valid;
      rsp_data_q <= rd_data;
      rsp_err_q <= rd_err;
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_data = rsp_data_q;
  assign link.rsp_err = rsp_err_q;

  // Value every sector lock bit takes on a reload
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sector_lock_boot_value_out <= 1'b0;
    end else if (reload_in) begin
      sector_lock_boot_value_out <= ~cfg_q[`CFG_BOOTLOCK];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_mode_out <= 1'b0;
      supply_lockdown_out <= 1'b0;
      permanent_mode_out <= 1'b0;
    end else begin
      key_mode_out <= ~cfg_q[`CFG_KEYMODE];
      supply_lockdown_out <= ~cfg_q[`CFG_SUPPLY];
      permanent_mode_out <= ~cfg_q[`CFG_PERM];
    end
  end

  // Permanent mode blocks regions even if guard reads one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      region_write_blocked_out <= 1'b0;
      region3_read_locked_out <= 1'b0;
    end else begin
      region_write_blocked_out <= ~guard_q | ~cfg_q[`CFG_PERM];
      region3_read_locked_out <= ~r3_q & ~cfg_q[`CFG_KEYMODE]
                                 & ~guard_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_word_out <= `CFG_ERASED;
      status_byte_out <= '0;
      program_error_out <= 1'b0;
    end else begin
      config_word_out <= cfg_q;
      status_byte_out <= stat_byte;
      program_error_out <= perr_q;
    end
  end

endmodule

`default_nettype wire

// ### otp_protection_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_otp_cfg.svh"

module otp_protection_host
  import prot_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Software register port
  input  wire logic [7:0]        addr_in,
  input  wire logic [`HREG_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [`HREG_W-1:0]     rdata_out,
  // Command link
  prot_link_if.host              link
);

  // True when two or more mode lock bits would be cleared
  function automatic logic multi_mode(input logic [2:0] b);
    multi_mode = (~b[2] & ~b[1]) | (~b[2] & ~b[0]) | (~b[1] & ~b[0]);
  endfunction

  logic [`HREG_W-1:0] wlo_q;
  logic [`HREG_W-1:0] whi_q;
  logic [`KEY_W-1:0]  rdata_q;
  logic [`KEY_W-1:0]  last_key_q;
  logic               busy_q;
  logic               done_q;
  logic               err_q;
  logic               refused_q;
  logic               window_q;
  logic               verified_q;
  logic               unlock_q;
  logic               cmd_valid_q;
  op_e                cmd_op_q;
  logic [`KEY_W-1:0]  cmd_data_q;
  logic               go;
  logic               refuse;
  op_e                req_op;
  logic [2:0]         req_modes;
  logic [`HREG_W-1:0] stat_word;

  assign go = wr_in && addr_in == `HR_CTRL && wdata_in[`CTRL_GO] && !busy_q;
  assign req_op = op_e'(wdata_in[`CTRL_OP_LSB +: `CTRL_OP_W]);
  assign req_modes = wlo_q[`CFG_KEYMODE:`CFG_PERM];

  always_comb begin
    refuse = 1'b0;
    if (req_op == OP_CFG_PROG) begin
      refuse = !window_q
               || multi_mode(req_modes)
               || (!req_modes[2] && !verified_q);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wlo_q <= '0;
      whi_q <= '0;
    end else if (wr_in && addr_in == `HR_WLO) begin
      wlo_q <= wdata_in;
    end else if (wr_in && addr_in == `HR_WHI) begin
      whi_q <= wdata_in;
    end
  end

  // Setup window closes once and stays closed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      window_q <= 1'b1;
    end else if (wr_in && addr_in == `HR_CTRL && wdata_in[`CTRL_CLOSE]) begin
      window_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_valid_q <= 1'b0;
      cmd_op_q <= OP_CFG_READ;
      cmd_data_q <= '0;
    end else begin
      cmd_valid_q <= go && !refuse;
      if (go && !refuse) begin
        cmd_op_q <= req_op;
        cmd_data_q <= {whi_q, wlo_q};
      end
    end
  end

  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_op = cmd_op_q;
  assign link.cmd_data = cmd_data_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      refused_q <= 1'b0;
      rdata_q <= '0;
    end else if (go) begin
      busy_q <= !refuse;
      done_q <= refuse;
      err_q <= refuse;
      refused_q <= refuse;
    end else if (busy_q && link.rsp_valid) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
      err_q <= link.rsp_err;
      rdata_q <= link.rsp_data;
    end
  end

  // Key counts as verified only after a matching read-back
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      verified_q <= 1'b0;
      last_key_q <= `KEY_ERASED;
    end else if (cmd_valid_q && cmd_op_q == OP_KEY_PROG) begin
      verified_q <= 1'b0;
      last_key_q <= cmd_data_q;
    end else if (busy_q && link.rsp_valid && cmd_op_q == OP_KEY_READ) begin
      verified_q <= !link.rsp_err && link.rsp_data == last_key_q;
    end
  end

  // Boot-protected sector locks need a release before array writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unlock_q <= 1'b1;
    end else if (busy_q && link.rsp_valid && cmd_op_q == OP_CFG_READ
                 && !link.rsp_err) begin
      unlock_q <= link.rsp_data[`CFG_BOOTLOCK];
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[`HS_BUSY] = busy_q;
    stat_word[`HS_DONE] = done_q;
    stat_word[`HS_ERR] = err_q;
    stat_word[`HS_REFUSED] = refused_q;
    stat_word[`HS_WINDOW] = window_q;
    stat_word[`HS_VERIFIED] = verified_q;
    stat_word[`HS_UNLOCK] = unlock_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        `HR_WLO:  rdata_out <= wlo_q;
        `HR_WHI:  rdata_out <= whi_q;
        `HR_RLO:  rdata_out <= rdata_q[`HREG_W-1:0];
        `HR_RHI:  rdata_out <= rdata_q[`KEY_W-1:`HREG_W];
        `HR_STAT: rdata_out <= stat_word;
        default:  rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire

// ### otp_protection_mode_lock_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_otp_cfg.svh"

module otp_protection_mode_lock_props
  import prot_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Link signals
  input  wire logic              cmd_valid,
  input  wire op_e               cmd_op,
  input  wire logic [`KEY_W-1:0] cmd_data,
  input  wire logic              rsp_valid,
  input  wire logic [`KEY_W-1:0] rsp_data,
  input  wire logic              rsp_err
);
  logic [2:0] mode_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Mode lock bits as the link has set them; blank part after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= 3'h7;
    end else if (cmd_valid && cmd_op == OP_CFG_PROG && mode_q == 3'h7) begin
      mode_q <= mode_q & cmd_data[2:0];
    end
  end

  property p_answer_next;
    cmd_valid |=> rsp_valid;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("no answer one cycle after a command");

  property p_answer_caused;
    rsp_valid |-> $past(cmd_valid);
  endproperty
  a_answer_caused: assert property (p_answer_caused)
    else $error("answer without a command");

  property p_host_spacing;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_host_spacing: assert property (p_host_spacing)
    else $error("commands back to back");

  property p_err_in_answer;
    rsp_err |-> rsp_valid;
  endproperty
  a_err_in_answer: assert property (p_err_in_answer)
    else $error("error flag outside an answer");

  property p_refused_blank;
    rsp_valid && rsp_err |-> rsp_data == '0;
  endproperty
  a_refused_blank: assert property (p_refused_blank)
    else $error("refused answer carries data");

  property p_mode_frozen;
    cmd_valid && cmd_op == OP_CFG_PROG |=> rsp_err == ($past(mode_q) != 3'h7);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode word program accepted or refused wrongly");

  property p_key_sealed;
    cmd_valid && (cmd_op == OP_KEY_READ || cmd_op == OP_KEY_PROG)
      && !mode_q[2] |=> rsp_err;
  endproperty
  a_key_sealed: assert property (p_key_sealed)
    else $error("key reachable in key mode");

  property p_cfg_read;
    cmd_valid && cmd_op == OP_CFG_READ |=>
      (rsp_data[15:0] & `CFG_RSV_MASK) == `CFG_RSV_MASK
      && rsp_data[2:0] == mode_q;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("mode word read wrong");

  property p_stat_read;
    cmd_valid && cmd_op == OP_STAT_READ |=> (rsp_data[7:0] & 8'hBE) == 8'h00;
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status reserved bits set");

  c_refused: cover property (rsp_valid && rsp_err);
  c_key_mode: cover property (mode_q == 3'h3);
  c_latch: cover property (cmd_valid && cmd_op == OP_STAT_LATCH);
endmodule

`default_nettype wire

// ### otp_protection_mode_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "prot_otp_cfg.svh"

module otp_protection_mode_lock_tb
  import prot_pkg::*;
  ();
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_s;
  logic        clk_in, rst_n_in, reload_in, err_clear_in, wr_in, rd_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [15:0] cfg, lo;
  logic [7:0]  stat;
  logic        boot, blk, r3lk, kmode, smode, pmode, perr, seen;
  logic [63:0] key;
  note_s       notes[$];
  int          failures, check_count;

  prot_link_if link ();
  otp_protection_host i_otp_protection_host (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link(link));
  otp_protection_mode_lock i_otp_protection_mode_lock (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reload_in(reload_in),
    .err_clear_in(err_clear_in), .link(link), .config_word_out(cfg),
    .status_byte_out(stat), .sector_lock_boot_value_out(boot),
    .region_write_blocked_out(blk), .region3_read_locked_out(r3lk),
    .key_mode_out(kmode), .supply_lockdown_out(smode),
    .permanent_mode_out(pmode), .program_error_out(perr));
  otp_protection_mode_lock_props i_otp_protection_mode_lock_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_err(link.rsp_err));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (seen && notes.size() > 0) begin
      cmp(notes[0].nm, notes[0].e & notes[0].m, rdata_out & notes[0].m);
      void'(notes.pop_front());
    end
    seen <= rd_in;
  end

  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    wr_in    <= w;
    rd_in    <= !w;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
  endtask
  task automatic idle(int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic rd(logic [7:0] a, string nm, logic [31:0] e, logic [31:0] m);
    notes.push_back('{nm, e, m});
    bus(1'b0, a, 32'h0);
  endtask
  // One command through the host, then its status bits
  task automatic run(logic [31:0] c, logic [63:0] d, logic [31:0] s,
                     logic [31:0] m);
    bus(1'b1, `HR_WLO, d[31:0]);
    bus(1'b1, `HR_WHI, d[63:32]);
    bus(1'b1, `HR_CTRL, c);
    idle(4);
    rd(`HR_STAT, "host status", s, m);
    idle(3);
  endtask
  task automatic pulse(logic r, logic e);
    reload_in    <= r;
    err_clear_in <= e;
    @(posedge clk_in);
    reload_in    <= 1'b0;
    err_clear_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic dev(logic [15:0] c, logic [7:0] s, logic [6:0] f);
    cmp("mode word", c, cfg);
    cmp("status byte", s, stat);
    cmp("flags", f, {boot, blk, r3lk, kmode, smode, pmode, perr});
  endtask
  // Fresh blank part; one-time cells return to erased
  task automatic blank();
    // Let a pending read answer land before reset clears it
    idle(2);
    rst_n_in <= 1'b0;
    idle(16);
    rst_n_in <= 1'b1;
    idle(2);
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_in);
    failures++;
    final_report();
  end

  initial begin
    {rst_n_in, reload_in, err_clear_in, wr_in, rd_in, seen} = 6'h00;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    failures = 0;
    check_count = 0;
    void'($urandom(32'h6FC19F37));
    key = {$urandom, $urandom};
    blank();
    dev(16'hFFFF, 8'h41, 7'h00);
    rd(8'h18, "unmapped", 32'h0, '1);
    run(32'h10 | OP_CFG_READ, 64'h0, 32'h52, 32'h7F);
    rd(`HR_RLO, "mode word read", 32'hFFFF, '1);
    run(32'h10 | OP_KEY_PROG, key, 32'h2, 32'hF);
    run(32'h10 | OP_KEY_READ, 64'h0, 32'h32, 32'h3F);
    rd(`HR_RLO, "key low", key[31:0], '1);
    rd(`HR_RHI, "key high", key[63:32], '1);
    run(32'h10 | OP_CFG_PROG, 64'hFFFC, 32'hE, 32'hF);
    run(32'h10 | OP_CFG_PROG, 64'hFFAF, 32'h2, 32'hF);
    run(32'h10 | OP_CFG_PROG, 64'hFFFF, 32'h2, 32'hF);
    dev(16'hFFAF, 8'h41, 7'h00);
    pulse(1'b1, 1'b0);
    dev(16'hFFAF, 8'h01, 7'h40);
    run(32'h10 | OP_CFG_PROG, 64'hFFFB, 32'h2, 32'hF);
    dev(16'hFFAB, 8'h01, 7'h48);
    run(32'h10 | OP_CFG_PROG, 64'hFFFE, 32'h6, 32'h7);
    dev(16'hFFAB, 8'h01, 7'h49);
    run(32'h10 | OP_KEY_READ, 64'h0, 32'h6, 32'h7);
    rd(`HR_RLO, "sealed key", 32'h0, '1);
    run(32'h10 | OP_KEY_PROG, 64'h0, 32'h6, 32'h7);
    run(32'h16, 64'h0, 32'h6, 32'h7);
    pulse(1'b1, 1'b0);
    dev(16'hFFAB, 8'h00, 7'h79);
    run(32'h10 | OP_STAT_LATCH, 64'h0, 32'h2, 32'hF);
    dev(16'hFFAB, 8'h01, 7'h49);
    pulse(1'b0, 1'b1);
    run(32'h10 | OP_STAT_READ, 64'h0, 32'h2, 32'hF);
    rd(`HR_RLO, "status read", 32'h01, '1);
    dev(16'hFFAB, 8'h01, 7'h48);
    for (int i = 0; i < 2; i++) begin
      blank();
      lo = 16'hFFFF ^ (16'h2 >> i);
      run(32'h10 | OP_CFG_PROG, {48'h0, lo}, 32'h2, 32'hF);
      run(32'h10 | OP_CFG_PROG, 64'hFFBF, 32'h6, 32'h7);
      pulse(1'b1, 1'b0);
      run(32'h10 | OP_STAT_LATCH, 64'h0, 32'h2, 32'h3);
      dev(lo, 8'h41, i ? 7'h23 : 7'h05);
    end
    blank();
    bus(1'b1, `HR_CTRL, 32'h100);
    run(32'h10 | OP_CFG_PROG, 64'hFFEF, 32'hE, 32'hF);
    dev(16'hFFFF, 8'h41, 7'h00);
    idle(4);
    final_report();
  end
endmodule

`default_nettype wire
